// >>> pkg/sec_pkg.sv
// Constants shared by the serial EEPROM controller, its EEPROM model and its bench
package sec_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int REG_AW = 8;
  localparam logic [7:0] REG_CMD_OFS = 8'hb0;
  localparam logic [7:0] REG_DATA_OFS = 8'hb4;
  localparam logic [7:0] REG_ISTS_OFS = 8'hb8;
  localparam logic [7:0] REG_IMASK_OFS = 8'hbc;

  // ---------------------------------------------------------------
  // Command register fields
  // ---------------------------------------------------------------
  localparam int CMD_BUSY_BIT = 31;
  localparam int CMD_OP_MSB = 30;
  localparam int CMD_OP_LSB = 28;
  localparam int CMD_TMO_BIT = 9;
  localparam int CMD_LOADED_BIT = 8;
  localparam int CMD_ADDR_MSB = 7;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [2:0] OP_RESET = 3'h0;

  // Software command codes
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_EWDS = 3'h1;
  localparam logic [2:0] OP_UNLOCK = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_BULK_WR = 3'h4;
  localparam logic [2:0] OP_ERASE = 3'h5;
  localparam logic [2:0] OP_BULK_ERASE = 3'h6;
  localparam logic [2:0] OP_RELOAD = 3'h7;

  // ---------------------------------------------------------------
  // Serial frame: start bit plus two opcode bits, then address, data
  // ---------------------------------------------------------------
  localparam int FRAME_W = 19;
  localparam logic [2:0] MW_HDR_READ = 3'h6;
  localparam logic [2:0] MW_HDR_WRITE = 3'h5;
  localparam logic [2:0] MW_HDR_ERASE = 3'h7;
  localparam logic [2:0] MW_HDR_SPECIAL = 3'h4;
  localparam logic [1:0] MW_SUB_UNLOCK = 2'h3;
  localparam logic [1:0] MW_SUB_EWDS = 2'h0;
  localparam logic [1:0] MW_SUB_BULK_ERASE = 2'h2;
  localparam logic [1:0] MW_SUB_BULK_WR = 2'h1;
  localparam logic [4:0] SEND_SHORT = 5'h0b;
  localparam logic [4:0] SEND_DATA = 5'h13;
  localparam logic [4:0] LAST_SHORT = 5'h0a;
  localparam logic [4:0] LAST_DATA = 5'h12;
  localparam logic [4:0] LAST_READ = 5'h13;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int SK_HZ = 1_000_000;
  localparam int HALF_CYC = (CLK_HZ + 2 * SK_HZ - 1) / (2 * SK_HZ);
  localparam int DIV_W = 5;
  localparam int TIMEOUT_MS = 30;
  localparam int TMO_CYC = CLK_HZ / 1000 * TIMEOUT_MS;
  localparam int TMO_W = 21;
  // Ready wait: CS register plus two sync flops before the pin is trusted
  localparam logic [1:0] RDY_SETTLE = 2'h3;

  // ---------------------------------------------------------------
  // Station address load
  // ---------------------------------------------------------------
  localparam logic [7:0] SIG_VALUE = 8'ha5;
  localparam int MAC_BYTES = 6;
  localparam logic [2:0] RL_FIRST = 3'h0;
  localparam logic [2:0] RL_LAST = 3'h6;

  // ---------------------------------------------------------------
  // Interrupt status bits
  // ---------------------------------------------------------------
  localparam int INT_W = 3;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_TMO_BIT = 1;
  localparam int INT_LOAD_BIT = 2;
  localparam logic [2:0] INT_RESET = 3'h0;

endpackage

// >>> verilog/sec_down_timer.sv
// Loadable down counter giving a one-cycle expiry pulse
`timescale 1ns/1ps
module sec_down_timer #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_load,
  input wire logic [W-1:0] i_load_val,
  output logic o_expire
);

  logic [W-1:0] cnt;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= '0;
      o_expire <= 1'b0;
    end else if (i_load) begin
      cnt <= i_load_val;
      o_expire <= 1'b0;
    end else begin
      // Stops at zero so the pulse fires once per load
      if (cnt != '0) begin
        cnt <= cnt - 1'b1;
      end
      o_expire <= (cnt == {{(W-1){1'b0}}, 1'b1});
    end
  end

endmodule // sec_down_timer

// >>> verilog/sec_serial_eeprom_ctrl.sv
// Serial EEPROM controller: registers, three-wire sequencer, address load
`timescale 1ns/1ps
module sec_serial_eeprom_ctrl
  import sec_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TMO_CYC
) (
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  input wire logic [REG_AW-1:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  output logic O_IRQ,
  output logic O_EE_CS,
  output logic O_EE_SK,
  output logic O_EE_DIO,
  output logic O_EE_DIO_OE,
  input wire logic I_EE_DIO,
  output logic [8*MAC_BYTES-1:0] O_STATION_ADDR,
  output logic O_ADDR_LOADED
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CS_SETUP,
    ST_BIT_LO,
    ST_BIT_HI,
    ST_CS_GAP,
    ST_WAIT_RDY,
    ST_FINISH
  } sec_state_e;

  sec_state_e state;
  logic din_meta, din_s;
  logic div_tick, tmo_expire;
  logic busy, frame_req, rl_active, cmd_timeout, addr_loaded;
  logic [2:0] rl_idx;
  logic [2:0] cmd_op, op_q;
  logic [7:0] cmd_addr, data_byte;
  logic [FRAME_W-1:0] tx_sh, f_bits;
  logic [4:0] bit_cnt, send_n, last_n, f_send, f_last;
  logic [8:0] rx_sh;
  logic [2:0] f_op;
  logic [7:0] f_addr;
  logic [INT_W-1:0] ists, imask, ev;
  logic launch, op_prog, wr_cmd, wr_start, frame_end, user_end, rl_end, sig_bad;
  logic [1:0] settle;
  logic rdy_ok;

  // ---------------------------------------------------------------
  // Pin input synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      din_meta <= 1'b0;
      din_s <= 1'b0;
    end else begin
      din_meta <= I_EE_DIO;
      din_s <= din_meta;
    end
  end

  // ---------------------------------------------------------------
  // Bit clock divider and response timeout
  // ---------------------------------------------------------------
  sec_down_timer #(.W(DIV_W)) u_div (
    .i_clk(I_CLK_SYS),
    .i_nrst(I_NRST),
    .i_load((state == ST_IDLE) || div_tick),
    .i_load_val(DIV_W'(HALF_CYC - 1)),
    .o_expire(div_tick)
  );

  sec_down_timer #(.W(TMO_W)) u_tmo (
    .i_clk(I_CLK_SYS),
    .i_nrst(I_NRST),
    .i_load(state != ST_WAIT_RDY),
    .i_load_val(TMO_W'(TIMEOUT_CYCLES - 1)),
    .o_expire(tmo_expire)
  );

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign wr_cmd = I_WR && (I_ADDR == REG_CMD_OFS) && !busy;
  assign wr_start = wr_cmd && I_WDATA[CMD_BUSY_BIT];
  assign launch = (state == ST_IDLE) && frame_req;
  assign op_prog = (op_q == OP_WRITE) || (op_q == OP_ERASE) ||
                   (op_q == OP_BULK_ERASE) || (op_q == OP_BULK_WR);
  assign rdy_ok = din_s && (settle == RDY_SETTLE);
  assign frame_end = (state == ST_FINISH);
  assign sig_bad = (rl_idx == RL_FIRST) && (rx_sh[7:0] != SIG_VALUE);
  assign rl_end = frame_end && rl_active && (sig_bad || (rl_idx == RL_LAST));
  assign user_end = frame_end && !rl_active;
  assign f_op = rl_active ? OP_READ : cmd_op;
  assign f_addr = rl_active ? {5'h00, rl_idx} : cmd_addr;

  // ---------------------------------------------------------------
  // Frame contents per command
  // ---------------------------------------------------------------
  always_comb begin
    f_bits = '0;
    f_send = SEND_SHORT;
    f_last = LAST_SHORT;
    case (f_op)
      OP_READ: begin
        f_bits = {MW_HDR_READ, f_addr, 8'h00};
        f_last = LAST_READ;
      end
      OP_WRITE: begin
        f_bits = {MW_HDR_WRITE, f_addr, data_byte};
        f_send = SEND_DATA;
        f_last = LAST_DATA;
      end
      OP_ERASE: f_bits = {MW_HDR_ERASE, f_addr, 8'h00};
      OP_UNLOCK: f_bits = {MW_HDR_SPECIAL, MW_SUB_UNLOCK, 14'h0000};
      OP_EWDS: f_bits = {MW_HDR_SPECIAL, MW_SUB_EWDS, 14'h0000};
      OP_BULK_ERASE: f_bits = {MW_HDR_SPECIAL, MW_SUB_BULK_ERASE, 14'h0000};
      OP_BULK_WR: begin
        f_bits = {MW_HDR_SPECIAL, MW_SUB_BULK_WR, 6'h00, data_byte};
        f_send = SEND_DATA;
        f_last = LAST_DATA;
      end
      default: f_bits = '0;
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (launch) begin
            state <= ST_CS_SETUP;
          end
        end
        ST_CS_SETUP: begin
          if (div_tick) begin
            state <= ST_BIT_LO;
          end
        end
        ST_BIT_LO: begin
          if (div_tick) begin
            state <= ST_BIT_HI;
          end
        end
        ST_BIT_HI: begin
          if (div_tick) begin
            state <= (bit_cnt == last_n) ? ST_CS_GAP : ST_BIT_LO;
          end
        end
        ST_CS_GAP: begin
          if (div_tick) begin
            state <= op_prog ? ST_WAIT_RDY : ST_FINISH;
          end
        end
        ST_WAIT_RDY: begin
          // Pin level from the idle gap is stale until settle runs out
          if (rdy_ok) begin
            state <= ST_FINISH;
          end else if (tmo_expire) begin
            state <= ST_IDLE;
          end
        end
        ST_FINISH: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Ready settle count
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      settle <= 2'h0;
    end else if (state != ST_WAIT_RDY) begin
      settle <= 2'h0;
    end else if (settle != RDY_SETTLE) begin
      settle <= settle + 2'h1;
    end
  end

  // Shift registers and frame length
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      tx_sh <= '0;
      rx_sh <= '0;
      bit_cnt <= 5'h00;
      send_n <= 5'h00;
      last_n <= 5'h00;
      op_q <= OP_RESET;
    end else if (launch) begin
      tx_sh <= f_bits;
      rx_sh <= '0;
      bit_cnt <= 5'h00;
      send_n <= f_send;
      last_n <= f_last;
      op_q <= f_op;
    end else if ((state == ST_BIT_HI) && div_tick) begin
      // Sampled at the end of the high phase, after the part has driven
      rx_sh <= {rx_sh[7:0], din_s};
      tx_sh <= {tx_sh[FRAME_W-2:0], 1'b0};
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // Pin drivers; one cycle behind the state, well inside a half bit
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      O_EE_CS <= 1'b0;
      O_EE_SK <= 1'b0;
      O_EE_DIO <= 1'b0;
      O_EE_DIO_OE <= 1'b0;
    end else begin
      O_EE_CS <= (state == ST_CS_SETUP) || (state == ST_BIT_LO) ||
                 (state == ST_BIT_HI) || (state == ST_WAIT_RDY);
      O_EE_SK <= (state == ST_BIT_HI);
      O_EE_DIO <= tx_sh[FRAME_W-1];
      O_EE_DIO_OE <= ((state == ST_BIT_LO) || (state == ST_BIT_HI)) && (bit_cnt < send_n);
    end
  end

  // ---------------------------------------------------------------
  // Job control: busy, reload walk, timeout and loaded flags
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      // Power-up load starts straight out of reset
      busy <= 1'b1;
      frame_req <= 1'b1;
      rl_active <= 1'b1;
      rl_idx <= RL_FIRST;
      cmd_timeout <= 1'b0;
      addr_loaded <= 1'b0;
    end else begin
      if (launch) begin
        frame_req <= 1'b0;
      end
      if (wr_start) begin
        busy <= 1'b1;
        frame_req <= 1'b1;
        cmd_timeout <= 1'b0;
        if (I_WDATA[CMD_OP_MSB:CMD_OP_LSB] == OP_RELOAD) begin
          rl_active <= 1'b1;
          rl_idx <= RL_FIRST;
          addr_loaded <= 1'b0;
        end
      end
      if ((state == ST_WAIT_RDY) && !rdy_ok && tmo_expire) begin
        busy <= 1'b0;
        cmd_timeout <= 1'b1;
      end
      if (user_end) begin
        busy <= 1'b0;
      end
      if (frame_end && rl_active) begin
        if (rl_end) begin
          busy <= 1'b0;
          rl_active <= 1'b0;
          addr_loaded <= !sig_bad;
        end else begin
          rl_idx <= rl_idx + 3'h1;
          frame_req <= 1'b1;
        end
      end
    end
  end

  assign O_ADDR_LOADED = addr_loaded;

  // Station address bytes, filled one per reload frame after the signature frame
  genvar g;
  generate
    for (g = 0; g < MAC_BYTES; g++) begin : g_sta
      always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
        if (!I_NRST) begin
          O_STATION_ADDR[8*g +: 8] <= 8'h00;
        end else if (frame_end && rl_active && (rl_idx == 3'(g + 1))) begin
          O_STATION_ADDR[8*g +: 8] <= rx_sh[7:0];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Software fields
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      cmd_addr <= ADDR_RESET;
      cmd_op <= OP_RESET;
    end else if (wr_cmd) begin
      cmd_addr <= I_WDATA[CMD_ADDR_MSB:0];
      cmd_op <= I_WDATA[CMD_OP_MSB:CMD_OP_LSB];
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      data_byte <= DATA_RESET;
    end else if (user_end && (op_q == OP_READ)) begin
      data_byte <= rx_sh[7:0];
    end else if (I_WR && (I_ADDR == REG_DATA_OFS) && !busy) begin
      data_byte <= I_WDATA[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Interrupts: sticky status, write one to clear, set wins
  // ---------------------------------------------------------------
  assign ev[INT_DONE_BIT] = user_end || rl_end;
  assign ev[INT_TMO_BIT] = (state == ST_WAIT_RDY) && !rdy_ok && tmo_expire;
  assign ev[INT_LOAD_BIT] = rl_end && !sig_bad;

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      ists <= INT_RESET;
      imask <= INT_RESET;
    end else begin
      if (I_WR && (I_ADDR == REG_ISTS_OFS)) begin
        ists <= (ists & ~I_WDATA[INT_W-1:0]) | ev;
      end else begin
        ists <= ists | ev;
      end
      if (I_WR && (I_ADDR == REG_IMASK_OFS)) begin
        imask <= I_WDATA[INT_W-1:0];
      end
    end
  end

  assign O_IRQ = |(ists & imask);

  // ---------------------------------------------------------------
  // Read port: data stand only in the cycle after the strobe
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      O_RDATA <= 32'h0000_0000;
    end else if (I_RD) begin
      case (I_ADDR)
        REG_CMD_OFS: O_RDATA <= {busy, cmd_op, 18'h00000, cmd_timeout, addr_loaded, cmd_addr};
        REG_DATA_OFS: O_RDATA <= {24'h000000, data_byte};
        REG_ISTS_OFS: O_RDATA <= {29'h00000000, ists};
        REG_IMASK_OFS: O_RDATA <= {29'h00000000, imask};
        default: O_RDATA <= 32'h0000_0000;
      endcase
    end else begin
      O_RDATA <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);

  sequence s_wait_expire;
    (state == ST_WAIT_RDY) && !rdy_ok && tmo_expire;
  endsequence

  sequence s_ready_seen;
    (state == ST_WAIT_RDY) && rdy_ok;
  endsequence

  tmo_abort_a: assert property (s_wait_expire |=> (state == ST_IDLE) && !busy)
    else $error("timeout did not abandon the operation");
  tmo_flag_a: assert property (s_wait_expire |=> cmd_timeout && ists[INT_TMO_BIT])
    else $error("timeout flag not set");
  rdy_release_a: assert property (s_ready_seen |=> (state == ST_FINISH) ##1 !busy)
    else $error("busy not released after ready");
  prog_wait_a: assert property ((state == ST_WAIT_RDY) |-> op_prog && !rl_active)
    else $error("non-programming command waits for ready");
  reload_clear_a: assert property (wr_start &&
      (I_WDATA[CMD_OP_MSB:CMD_OP_LSB] == OP_RELOAD) |=> !addr_loaded [*2])
    else $error("loaded flag not cleared by reload");
  loaded_set_a: assert property ($rose(addr_loaded) |->
      (rl_idx == RL_LAST) && !rl_active && !busy)
    else $error("loaded flag set before all address bytes");
  addr_field_a: assert property (wr_cmd |=> cmd_addr == $past(I_WDATA[7:0]))
    else $error("address field not written");
  data_field_a: assert property (I_WR && (I_ADDR == REG_DATA_OFS) && !busy
      |=> data_byte == $past(I_WDATA[7:0]))
    else $error("data field not written");
  data_rsv_a: assert property (I_RD && (I_ADDR == REG_DATA_OFS)
      |=> (O_RDATA[31:8] == 24'h000000) && (O_RDATA[7:0] == data_byte))
    else $error("data register reserved bits not zero");
  read_load_a: assert property (user_end && (op_q == OP_READ)
      |=> data_byte == $past(rx_sh[7:0]))
    else $error("read byte not placed in data register");
  busy_hold_a: assert property (busy && I_WR && (I_ADDR == REG_CMD_OFS)
      |=> cmd_addr == $past(cmd_addr))
    else $error("command field changed while busy");

endmodule // sec_serial_eeprom_ctrl

// >>> tb/sec_eeprom_model.sv
// Behavioural three-wire serial EEPROM facing the controller
`timescale 1ns/1ps
module sec_eeprom_model
  import sec_pkg::*;
(
  input wire logic i_cs,
  input wire logic i_sk,
  input wire logic i_di,
  input wire logic i_slow,
  output logic o_do,
  output logic o_oe
);
  logic [7:0] mem [256];
  logic [18:0] sr;
  logic [8:0] rd;
  logic [2:0] hdr;
  logic [1:0] sub;
  logic [7:0] adr;
  logic unlock, ready, stat, prog, rbit;
  int cnt;
  assign o_do = stat ? ready : rbit;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'h10 + 8'(i);
    end
    mem[0] = SIG_VALUE;
    {unlock, stat, prog, rbit, o_oe, hdr, sub, adr, sr, rd} = '0;
    ready = 1'b1;
    cnt = 0;
  end
  // ---------------------------------------------------------------
  // Deselect ends a frame; programming runs from here
  // ---------------------------------------------------------------
  always @(negedge i_cs) begin
    cnt = 0;
    o_oe = 1'b0;
    hdr = 3'h0;
    if (prog) begin
      prog = 1'b0;
      stat = 1'b1;
      ready = 1'b0;
      ready <= #(i_slow ? 4000 : 300) 1'b1;
    end
  end
  // Ready status only shows after a real programming cycle
  always @(posedge i_cs) o_oe = stat;
  always @(posedge i_sk) begin
    if (i_cs) begin
      sr = {sr[17:0], i_di};
      cnt = cnt + 1;
      stat = 1'b0;
      o_oe = 1'b0;
      if (cnt == 11) begin
        hdr = sr[10:8];
        sub = sr[7:6];
        adr = sr[7:0];
        rd = {1'b0, mem[adr]};
        if (hdr == MW_HDR_SPECIAL && sub == MW_SUB_UNLOCK) unlock = 1'b1;
        if (hdr == MW_HDR_SPECIAL && sub == MW_SUB_EWDS) unlock = 1'b0;
        if (unlock && hdr == MW_HDR_ERASE) begin
          mem[adr] = 8'hff;
          prog = 1'b1;
        end
        if (unlock && hdr == MW_HDR_SPECIAL && sub == MW_SUB_BULK_ERASE) begin
          for (int i = 0; i < 256; i++) mem[i] = 8'hff;
          prog = 1'b1;
        end
      end
      if (hdr == MW_HDR_READ && cnt >= 12 && cnt <= 20) begin
        rbit = rd[20 - cnt];
        o_oe = 1'b1;
      end
      if (cnt == 19 && unlock && hdr == MW_HDR_WRITE) begin
        mem[adr] = sr[7:0];
        prog = 1'b1;
      end
      if (cnt == 19 && unlock && hdr == MW_HDR_SPECIAL && sub == MW_SUB_BULK_WR) begin
        for (int i = 0; i < 256; i++) mem[i] = sr[7:0];
        prog = 1'b1;
      end
    end
  end
endmodule // sec_eeprom_model

// >>> tb/sec_serial_eeprom_controller_bench.sv
// Self-checking bench for the serial EEPROM controller
`timescale 1ns/1ps
module sec_serial_eeprom_controller_bench;
  import sec_pkg::*;
  localparam int TMO = 200;
  logic I_CLK_SYS = 1'b0;
  logic I_NRST = 1'b0;
  logic [7:0] I_ADDR = 8'h00;
  logic [31:0] I_WDATA = 32'h0;
  logic I_WR = 1'b0;
  logic I_RD = 1'b0;
  logic [31:0] O_RDATA;
  logic O_IRQ, O_EE_CS, O_EE_SK, O_EE_DIO, O_EE_DIO_OE, O_ADDR_LOADED;
  logic [47:0] O_STATION_ADDR;
  logic ee_do, ee_oe, dio;
  logic present = 1'b1;
  logic pull = 1'b1;
  logic slow = 1'b0;
  logic [7:0] sh [256];
  logic [31:0] v;
  logic [7:0] a, d;
  int failures = 0;
  int checks_done = 0;
  int seed, cyc, t0, el, base;
  // Absent part: its pins float to the bench pull level
  assign dio = O_EE_DIO_OE ? O_EE_DIO : ((present && ee_oe) ? ee_do : pull);
  always #12.5 I_CLK_SYS = ~I_CLK_SYS;
  sec_serial_eeprom_ctrl #(.TIMEOUT_CYCLES(TMO)) uut (.I_CLK_SYS(I_CLK_SYS),
    .I_NRST(I_NRST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
    .O_RDATA(O_RDATA), .O_IRQ(O_IRQ), .O_EE_CS(O_EE_CS), .O_EE_SK(O_EE_SK),
    .O_EE_DIO(O_EE_DIO), .O_EE_DIO_OE(O_EE_DIO_OE), .I_EE_DIO(dio),
    .O_STATION_ADDR(O_STATION_ADDR), .O_ADDR_LOADED(O_ADDR_LOADED));
  sec_eeprom_model eeprom (.i_cs(O_EE_CS & present), .i_sk(O_EE_SK), .i_di(dio),
    .i_slow(slow), .o_do(ee_do), .o_oe(ee_oe));
  // ---------------------------------------------------------------
  // Bus tasks and checks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge I_CLK_SYS) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge I_CLK_SYS);
    I_WR <= 1'b1;
    I_ADDR <= ad;
    I_WDATA <= dt;
    @(posedge I_CLK_SYS);
    I_WR <= 1'b0;
    // Let the write settle before any output is looked at
    #1;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] dt);
    @(posedge I_CLK_SYS);
    I_RD <= 1'b1;
    I_ADDR <= ad;
    @(posedge I_CLK_SYS);
    I_RD <= 1'b0;
    #1 dt = O_RDATA;
  endtask
  // Polls until busy drops; a hang counts as a mismatch
  task automatic poll();
    int k;
    k = 0;
    v = 32'hffffffff;
    while (v[CMD_BUSY_BIT] !== 1'b0 && k < 8000) begin
      rd(REG_CMD_OFS, v);
      k++;
    end
    el = cyc - t0;
    if (k >= 8000) begin
      failures++;
      end_of_test();
    end
  endtask
  task automatic run(input logic [2:0] op, input logic [7:0] ad);
    wr(REG_CMD_OFS, {1'b1, op, 20'h0, ad});
    t0 = cyc;
    // Store while busy: must be ignored
    wr(REG_CMD_OFS, {8'h00, 16'h0, ~ad});
    poll();
    check(v[7:0], ad);
  endtask
  task automatic read_back(input logic [7:0] ad);
    run(OP_READ, ad);
    rd(REG_DATA_OFS, v);
    check(v, {24'h0, sh[ad]});
  endtask
  function automatic logic [47:0] exp_station();
    logic [47:0] r;
    for (int k = 0; k < MAC_BYTES; k++) r[8*k +: 8] = sh[k+1];
    return r;
  endfunction
  function automatic logic exp_tmo(input logic [2:0] op);
    return op == OP_WRITE || op == OP_BULK_WR || op == OP_ERASE || op == OP_BULK_ERASE;
  endfunction
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h09948d19;
    cyc = 0;
    for (int i = 0; i < 256; i++) sh[i] = 8'h10 + 8'(i);
    sh[0] = SIG_VALUE;
    repeat (16) @(posedge I_CLK_SYS);
    I_NRST <= 1'b1;
    poll();
    check(v[9:0], 10'h100);
    check(O_ADDR_LOADED, 1'b1);
    check(O_STATION_ADDR, exp_station());
    rd(REG_DATA_OFS, v);
    check(v, 32'h0);
    rd(REG_ISTS_OFS, v);
    check(v, 32'h5);
    $display("power-up load test done");
    wr(REG_CMD_OFS, 32'h000003c3);
    rd(REG_CMD_OFS, v);
    check(v, 32'h000001c3);
    wr(REG_DATA_OFS, 32'hffffffff);
    rd(REG_DATA_OFS, v);
    check(v, 32'h000000ff);
    wr(8'hc0, 32'hffffffff);
    rd(8'hc0, v);
    check(v, 32'h0);
    wr(REG_IMASK_OFS, 32'h4);
    check(O_IRQ, 1'b1);
    wr(REG_ISTS_OFS, 32'h7);
    check(O_IRQ, 1'b0);
    $display("register test done");
    run(OP_EWDS, 8'h00);
    a = 8'($random(seed));
    wr(REG_DATA_OFS, {24'h0, ~sh[a]});
    run(OP_WRITE, a);
    read_back(a);
    run(OP_UNLOCK, 8'h00);
    for (int i = 0; i < 4; i++) begin
      a = 8'($random(seed));
      d = 8'($random(seed));
      slow <= i[0];
      wr(REG_DATA_OFS, {24'h0, d});
      run(OP_WRITE, a);
      check(v[CMD_TMO_BIT], 1'b0);
      if (i == 0) base = el;
      if (i == 1) check(el >= base + 120, 1'b1);
      sh[a] = d;
      read_back(a);
    end
    run(OP_ERASE, a);
    sh[a] = 8'hff;
    read_back(a);
    d = 8'($random(seed));
    wr(REG_DATA_OFS, {24'h0, d});
    run(OP_BULK_WR, 8'h00);
    for (int i = 0; i < 256; i++) sh[i] = d;
    read_back(8'($random(seed)));
    run(OP_BULK_ERASE, 8'h00);
    for (int i = 0; i < 256; i++) sh[i] = 8'hff;
    read_back(8'($random(seed)));
    $display("program test done");
    run(OP_RELOAD, 8'h00);
    check(v[CMD_LOADED_BIT], 1'b0);
    check(O_ADDR_LOADED, 1'b0);
    for (int i = 0; i <= MAC_BYTES; i++) begin
      sh[i] = (i == 0) ? SIG_VALUE : 8'($random(seed));
      wr(REG_DATA_OFS, {24'h0, sh[i]});
      run(OP_WRITE, 8'(i));
    end
    run(OP_RELOAD, 8'h00);
    check(v[CMD_LOADED_BIT], 1'b1);
    check(O_STATION_ADDR, exp_station());
    $display("reload test done");
    present <= 1'b0;
    run(OP_WRITE, 8'h01);
    base = el;
    check(v[CMD_TMO_BIT], 1'b0);
    run(OP_READ, 8'h01);
    rd(REG_DATA_OFS, v);
    check(v, 32'hff);
    $display("pulled-high absent test done");
    pull <= 1'b0;
    wr(REG_ISTS_OFS, 32'h7);
    wr(REG_IMASK_OFS, 32'h2);
    for (int op = 0; op < 8; op++) begin
      run(3'(op), 8'h01);
      check(v[CMD_TMO_BIT], exp_tmo(3'(op)));
      check(O_IRQ, exp_tmo(3'(op)));
      if (op == OP_WRITE) begin
        check(el >= base + TMO - 8 && el <= base + TMO + 8, 1'b1);
      end
      wr(REG_ISTS_OFS, 32'h7);
      check(O_IRQ, 1'b0);
    end
    present <= 1'b1;
    pull <= 1'b1;
    run(OP_READ, 8'h01);
    check(v[CMD_TMO_BIT], 1'b0);
    $display("pulled-low absent test done");
    end_of_test();
  end
endmodule // sec_serial_eeprom_controller_bench
